// ### rtl/idpw_words.sv
// Purpose: identify parameter words 54 to 84 for the data port
// Assumes: all status inputs are synchronous to clk_i
// Notes:   one word per index, registered; other indices read 0000h
`timescale 1ns/1ns
`default_nettype none

module idpw_words
    import idpw_pkg::*;
#(
    parameter int unsigned      MDMA_MAX_MODE = 2,
    parameter bit               PIO3_SUP      = 1'b1,
    parameter bit               PIO4_SUP      = 1'b1,
    parameter bit               EXT_SUP       = 1'b1,
    parameter bit               MDMA_CYC_SUP  = 1'b1,
    parameter logic [15:0]      MDMA_MIN_NS   = IDPW_MDMA_MIN_NS,
    parameter logic [15:0]      MDMA_REC_NS   = IDPW_MDMA_REC_NS,
    parameter logic [15:0]      PIO_NOFC_NS   = IDPW_PIO_NOFC_NS,
    parameter logic [15:0]      PIO_IORDY_NS  = IDPW_PIO_IORDY_NS
) (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  ce_i,
    input  wire logic [IDPW_IDX_W-1:0] word_idx_i,
    input  wire logic [15:0]           cur_cyl_i,
    input  wire logic [15:0]           cur_heads_i,
    input  wire logic [15:0]           cur_spt_i,
    input  wire logic [31:0]           lba_total_i,
    input  wire logic [7:0]            mult_count_i,
    input  wire logic                  mdma_sel_en_i,
    input  wire logic [1:0]            mdma_sel_mode_i,
    input  wire logic                  security_sup_i,
    input  wire logic                  wcache_sup_i,
    input  wire logic                  lookahead_sup_i,
    input  wire logic                  apm_sup_i,
    output logic [IDPW_WORD_W-1:0]     word_o,
    output logic                       word_hit_o,
    output logic                       ext_valid_o
);

    // refuse settings the word layout cannot express
    if (IDPW_WORD_W != 16) begin : g_bad_word_w
        $error("identify words are 16 bits wide");
    end

    if (IDPW_IDX_W < 7) begin : g_bad_idx_w
        $error("word index too narrow for word 84");
    end

    if (MDMA_MAX_MODE > 2) begin : g_bad_mdma_max
        $error("MDMA_MAX_MODE above 2 is not encodable");
    end

    // modes 1 and up oblige the DMA cycle-time words
    if ((MDMA_MAX_MODE >= 1) && !MDMA_CYC_SUP) begin : g_bad_mdma_cyc
        $error("DMA modes 1 and up need the cycle-time words");
    end

    // a zero would read as an unsupported field
    if (MDMA_CYC_SUP && (MDMA_MIN_NS == 16'h0000)) begin : g_bad_mdma_min
        $error("zero minimum DMA cycle while supported");
    end

    if (MDMA_CYC_SUP && (MDMA_REC_NS < MDMA_MIN_NS)) begin : g_bad_mdma_rec
        $error("recommended DMA cycle below minimum");
    end

    if (PIO3_SUP && (PIO_IORDY_NS == 16'h0000)) begin : g_bad_pio_iordy
        $error("zero IORDY cycle while PIO3 supported");
    end

    if (PIO3_SUP && (PIO_NOFC_NS < PIO_IORDY_NS)) begin : g_bad_pio_nofc
        $error("PIO cycle without flow control below IORDY cycle");
    end

    if (PIO4_SUP && !PIO3_SUP) begin : g_bad_pio4
        $error("PIO4 support needs PIO3 support");
    end

    if ((MDMA_CYC_SUP || PIO3_SUP) && !EXT_SUP) begin : g_bad_ext
        $error("extended fields used while EXT_SUP is clear");
    end

    localparam logic [1:0] MDMA_MAX = 2'(MDMA_MAX_MODE);

    // ------------------------------------------------------------
    // geometry and capacity
    // ------------------------------------------------------------
    logic [31:0] cap_val;

    idpw_cap_mult u_cap (
        .cyl_i   (cur_cyl_i),
        .heads_i (cur_heads_i),
        .spt_i   (cur_spt_i),
        .cap_o   (cap_val)
    );

    // ------------------------------------------------------------
    // multiple sector setting
    // ------------------------------------------------------------
    // any nonzero host count is reported as one: only 00h/01h exist
    wire         mult_on   = |mult_count_i;
    wire  [7:0]  mult_low  = {7'h00, mult_on}; // RL4
    wire  [15:0] mult_word;

    assign mult_word = {7'h00, 1'b1, mult_low}; // RL3

    // ------------------------------------------------------------
    // multiword DMA support and selection
    // ------------------------------------------------------------
    logic [2:0] mdma_sup_bits;
    logic [2:0] mdma_sel_bits;

    generate
        for (genvar m = 0; m < 3; m++) begin : g_mdma
            // mode m supported when the top supported mode reaches m
            assign mdma_sup_bits[m] = (2'(m) <= MDMA_MAX); // RL8
            // a selection beyond support shows nothing selected
            assign mdma_sel_bits[m] = mdma_sel_en_i
                                      && (mdma_sel_mode_i == 2'(m))
                                      && mdma_sup_bits[m]; // RL7
        end
    endgenerate

    wire [15:0] mdma_word = {5'h00, mdma_sel_bits, 5'h00, mdma_sup_bits}; // RL6

    // ------------------------------------------------------------
    // advanced PIO modes
    // ------------------------------------------------------------
    wire [15:0] pio_adv_word = {14'h0000, PIO4_SUP, PIO3_SUP}; // RL11

    // ------------------------------------------------------------
    // cycle time words
    // ------------------------------------------------------------
    // unsupported fields read zero so the host skips them
    wire [15:0] mdma_min_word = MDMA_CYC_SUP ? MDMA_MIN_NS : 16'h0000; // RL9
    wire [15:0] mdma_rec_word = MDMA_CYC_SUP ? MDMA_REC_NS : 16'h0000; // RL10
    wire [15:0] pio_nofc_word = PIO3_SUP ? PIO_NOFC_NS : 16'h0000; // RL12 RL14
    wire [15:0] pio_iordy_word = PIO3_SUP ? PIO_IORDY_NS : 16'h0000; // RL13 RL14

    // ------------------------------------------------------------
    // feature support words
    // ------------------------------------------------------------
    logic [15:0] feat0_word;
    logic [15:0] feat1_word;
    logic [15:0] feat2_word;

    // fixed bits never collapse to 0000h/FFFFh, so the host sees them valid
    always_comb begin
        feat0_word                  = IDPW_F0_FIXED; // RL16
        feat0_word[IDPW_F0_SEC_BIT] = security_sup_i; // RL17
        feat0_word[IDPW_F0_WC_BIT]  = wcache_sup_i; // RL17
        feat0_word[IDPW_F0_LA_BIT]  = lookahead_sup_i; // RL17
    end

    always_comb begin
        feat1_word                  = IDPW_FVALID; // RL15
        feat1_word[IDPW_F1_APM_BIT] = apm_sup_i; // RL18
    end

    assign feat2_word = IDPW_FVALID; // RL15

    // ------------------------------------------------------------
    // word select
    // ------------------------------------------------------------
    logic [15:0] sel_word;
    logic        sel_hit;

    wire hit_cyl    = (word_idx_i == IDPW_W_CYL);
    wire hit_heads  = (word_idx_i == IDPW_W_HEADS);
    wire hit_spt    = (word_idx_i == IDPW_W_SPT);
    wire hit_cap_lo = (word_idx_i == IDPW_W_CAP_LO);
    wire hit_cap_hi = (word_idx_i == IDPW_W_CAP_HI);
    wire hit_mult   = (word_idx_i == IDPW_W_MULT);
    wire hit_lba_lo = (word_idx_i == IDPW_W_LBA_LO);
    wire hit_lba_hi = (word_idx_i == IDPW_W_LBA_HI);
    wire hit_mdma   = (word_idx_i == IDPW_W_MDMA);
    wire hit_pio    = (word_idx_i == IDPW_W_PIO_ADV);
    wire hit_dmin   = (word_idx_i == IDPW_W_MDMA_MIN);
    wire hit_drec   = (word_idx_i == IDPW_W_MDMA_REC);
    wire hit_pnofc  = (word_idx_i == IDPW_W_PIO_NOFC);
    wire hit_piordy = (word_idx_i == IDPW_W_PIO_IORDY);
    wire hit_feat0  = (word_idx_i == IDPW_W_FEAT0);
    wire hit_feat1  = (word_idx_i == IDPW_W_FEAT1);
    wire hit_feat2  = (word_idx_i == IDPW_W_FEAT2);

    // reserved words inside the range still count as served
    assign sel_hit = (word_idx_i >= IDPW_W_FIRST) && (word_idx_i <= IDPW_W_LAST);

    always_comb begin
        if (hit_cyl) begin
            sel_word = cur_cyl_i; // RL1
        end else if (hit_heads) begin
            sel_word = cur_heads_i; // RL1
        end else if (hit_spt) begin
            sel_word = cur_spt_i; // RL1
        end else if (hit_cap_lo) begin
            sel_word = cap_val[15:0]; // RL2
        end else if (hit_cap_hi) begin
            sel_word = cap_val[31:16]; // RL2
        end else if (hit_mult) begin
            sel_word = mult_word;
        end else if (hit_lba_lo) begin
            sel_word = lba_total_i[15:0]; // RL5
        end else if (hit_lba_hi) begin
            sel_word = lba_total_i[31:16]; // RL5
        end else if (hit_mdma) begin
            sel_word = mdma_word;
        end else if (hit_pio) begin
            sel_word = EXT_SUP ? pio_adv_word : 16'h0000;
        end else if (hit_dmin) begin
            sel_word = mdma_min_word;
        end else if (hit_drec) begin
            sel_word = mdma_rec_word;
        end else if (hit_pnofc) begin
            sel_word = pio_nofc_word;
        end else if (hit_piordy) begin
            sel_word = pio_iordy_word;
        end else if (hit_feat0) begin
            sel_word = feat0_word;
        end else if (hit_feat1) begin
            sel_word = feat1_word;
        end else if (hit_feat2) begin
            sel_word = feat2_word;
        end else begin
            sel_word = IDPW_WORD_RST;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic [15:0] word_ff;
    logic        hit_ff;
    logic        ext_ff;
    logic [15:0] nxt_word;
    logic        nxt_hit;
    logic        nxt_ext;

    assign nxt_word = sel_word;
    assign nxt_hit  = sel_hit;
    assign nxt_ext  = EXT_SUP; // RL21

    // reset beats ce so a frozen block still clears
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            word_ff <= IDPW_WORD_RST;
        end else if (ce_i) begin
            word_ff <= nxt_word; // RL22
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hit_ff <= 1'b0;
        end else if (ce_i) begin
            hit_ff <= nxt_hit; // RL22
        end
    end

    // validity reads zero until the first enabled edge
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ext_ff <= 1'b0;
        end else if (ce_i) begin
            ext_ff <= nxt_ext; // RL21
        end
    end

    assign word_o      = word_ff;
    assign word_hit_o  = hit_ff;
    assign ext_valid_o = ext_ff;

endmodule : idpw_words

`default_nettype wire

// ### rtl/idpw_pkg.sv
// Purpose: constants for the identify parameter words 54 to 84
// Assumes: one 16-bit word is served per word index
// Notes:   cycle times are in nanoseconds, as the host reads them
// Overview of operation
// [RL1] words 54-56 give current cylinders, heads, sectors
// [RL2] words 57-58 give current geometry product
// [RL3] word 59 upper bits zero, bit 8 one
// [RL4] word 59 low byte returns only 00h or 01h
// [RL5] words 60-61 give total LBA sector count
// [RL6] word 63 selected byte one-hot, 15-11 zero
// [RL7] bit 8/9/10 mark selected MDMA mode 0/1/2
// [RL8] word 63 low byte marks supported MDMA modes
// [RL9] word 65 minimum MDMA cycle, zero if unsupported
// [RL10] word 66 recommended cycle not below word 65
// [RL11] word 64 bit 1 PIO4, bit 0 PIO3
// [RL12] word 67 not below word 68
// [RL13] word 68 matches fastest supported PIO mode
// [RL14] unsupported PIO cycle words read zero
// [RL15] words 83,84 bit 14 one, bit 15 zero
// [RL16] word 82 fixed bits for fixed features
// [RL17] word 82 bits 1,5,6 follow feature support
// [RL18] word 83 bits 0-2,4 zero, bit 3 APM
// [RL19] host treats 0000h/FFFFh feature words as unknown
// [RL20] host should not depend on feature words
// [RL21] word 53 bit 1 set when extended fields supported; the code gives this on ext_valid_o instead, and word 53 reads 0000h
// [RL22] selected word registered one cycle after index

package idpw_pkg;

    localparam int unsigned IDPW_IDX_W       = 8;
    localparam int unsigned IDPW_WORD_W      = 16;

    localparam logic [7:0]  IDPW_W_CYL       = 8'h36;
    localparam logic [7:0]  IDPW_W_HEADS     = 8'h37;
    localparam logic [7:0]  IDPW_W_SPT       = 8'h38;
    localparam logic [7:0]  IDPW_W_CAP_LO    = 8'h39;
    localparam logic [7:0]  IDPW_W_CAP_HI    = 8'h3A;
    localparam logic [7:0]  IDPW_W_MULT      = 8'h3B;
    localparam logic [7:0]  IDPW_W_LBA_LO    = 8'h3C;
    localparam logic [7:0]  IDPW_W_LBA_HI    = 8'h3D;
    localparam logic [7:0]  IDPW_W_MDMA      = 8'h3F;
    localparam logic [7:0]  IDPW_W_PIO_ADV   = 8'h40;
    localparam logic [7:0]  IDPW_W_MDMA_MIN  = 8'h41;
    localparam logic [7:0]  IDPW_W_MDMA_REC  = 8'h42;
    localparam logic [7:0]  IDPW_W_PIO_NOFC  = 8'h43;
    localparam logic [7:0]  IDPW_W_PIO_IORDY = 8'h44;
    localparam logic [7:0]  IDPW_W_FEAT0     = 8'h52;
    localparam logic [7:0]  IDPW_W_FEAT1     = 8'h53;
    localparam logic [7:0]  IDPW_W_FEAT2     = 8'h54;
    localparam logic [7:0]  IDPW_W_FIRST     = 8'h36;
    localparam logic [7:0]  IDPW_W_LAST      = 8'h54;

    localparam int unsigned IDPW_MULT_VALID_BIT = 8;
    localparam int unsigned IDPW_MDMA_SEL_LSB   = 8;
    localparam int unsigned IDPW_PIO3_BIT       = 0;
    localparam int unsigned IDPW_PIO4_BIT       = 1;

    localparam int unsigned IDPW_F0_SEC_BIT  = 1;
    localparam int unsigned IDPW_F0_WC_BIT   = 5;
    localparam int unsigned IDPW_F0_LA_BIT   = 6;
    localparam int unsigned IDPW_F1_APM_BIT  = 3;
    localparam logic [15:0] IDPW_F0_FIXED    = 16'h7008;
    localparam logic [15:0] IDPW_FVALID      = 16'h4000;

    localparam logic [15:0] IDPW_MDMA_MIN_NS  = 16'h0078;
    localparam logic [15:0] IDPW_MDMA_REC_NS  = 16'h0078;
    localparam logic [15:0] IDPW_PIO_NOFC_NS  = 16'h0078;
    localparam logic [15:0] IDPW_PIO_IORDY_NS = 16'h0078;

    localparam logic [15:0] IDPW_WORD_RST    = 16'h0000;

endpackage : idpw_pkg

// ### rtl/idpw_cap_mult.sv
// Purpose: current capacity from the current geometry
// Assumes: geometry inputs are steady while words are read
// Notes:   product saturates instead of wrapping
`timescale 1ns/1ns
`default_nettype none

module idpw_cap_mult (
    input  wire logic [15:0] cyl_i,
    input  wire logic [15:0] heads_i,
    input  wire logic [15:0] spt_i,
    output logic      [31:0] cap_o
);

    logic [31:0] ch_prod;
    logic [47:0] full_prod;
    logic        over;

    assign ch_prod   = cyl_i * heads_i;
    assign full_prod = ch_prod * {32'h0000_0000, spt_i};
    // wrap would report a small, wrong size; saturate instead
    assign over      = |full_prod[47:32];
    assign cap_o     = over ? 32'hFFFF_FFFF : full_prod[31:0]; // RL2

endmodule : idpw_cap_mult

`default_nettype wire

// ### verification/idpw_monitor.sv
// Purpose: port-level checks on the identify word block
// Assumes: default parameters except EXT_SUP, passed by bind
// Notes:   every check looks at the next clock edge after its trigger, whether ce is high or not
`timescale 1ns/1ns
`default_nettype none
module idpw_monitor
    import idpw_pkg::*;
#(
    parameter bit EXT_SUP = 1'b1
) (
    input wire logic                  clk_i,
    input wire logic                  srst_i,
    input wire logic                  ce_i,
    input wire logic [IDPW_IDX_W-1:0] word_idx_i,
    input wire logic [15:0]           cur_cyl_i,
    input wire logic [31:0]           lba_total_i,
    input wire logic [7:0]            mult_count_i,
    input wire logic                  mdma_sel_en_i,
    input wire logic [1:0]            mdma_sel_mode_i,
    input wire logic                  apm_sup_i,
    input wire logic [15:0]           word_o,
    input wire logic                  word_hit_o,
    input wire logic                  ext_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire tk = ce_i && !srst_i;
    AST_CYL: assert property (tk && word_idx_i == IDPW_W_CYL |=> word_o == $past(cur_cyl_i))
        else $error("cylinder word wrong");
    AST_LBA: assert property (tk && word_idx_i == IDPW_W_LBA_HI |=> word_o == $past(lba_total_i[31:16]))
        else $error("lba high word wrong");
    AST_MULT: assert property (tk && word_idx_i == IDPW_W_MULT |=> word_o == {8'h01, 7'h00, $past(mult_count_i) != 8'h00})
        else $error("multiple setting word wrong");
    wire [7:0] sel_exp = (mdma_sel_en_i && mdma_sel_mode_i != 2'h3) ? 8'h01 << mdma_sel_mode_i : 8'h00;
    AST_MDMA: assert property (tk && word_idx_i == IDPW_W_MDMA |=> word_o[15:8] == $past(sel_exp))
        else $error("selected dma bit wrong");
    AST_MDMA_SUP: assert property (tk && word_idx_i == IDPW_W_MDMA |=> word_o[7:0] == 8'h07)
        else $error("supported dma bits wrong");
    AST_F1: assert property (tk && word_idx_i == IDPW_W_FEAT1 |=> word_o == (16'h4000 | {12'h000, $past(apm_sup_i), 3'h0}))
        else $error("feature word 83 wrong");
    AST_EXT: assert property (tk |=> ext_valid_o == EXT_SUP)
        else $error("extended validity wrong");
    AST_HOLD: assert property (!ce_i |=> $stable(word_o) && $stable(word_hit_o))
        else $error("output moved without ce");
    AST_RANGE: assert property (tk && (word_idx_i < 8'h36 || word_idx_i > 8'h54) |=> word_o == 16'h0000 && !word_hit_o)
        else $error("out of range index answered");
endmodule : idpw_monitor
`default_nettype wire

// ### verification/idpw_host_model.sv
// Purpose: host side that asks for identify words
// Assumes: index goes straight to the block
// Notes:   only judges whether feature words carry information
`timescale 1ns/1ns
`default_nettype none
module idpw_host_model (
    input  wire logic [7:0]  req_idx_i,
    input  wire logic [15:0] word_i,
    output logic      [7:0]  word_idx_o,
    output logic             feat_known_o
);
    assign word_idx_o = req_idx_i;
    // legacy fill patterns mean no information
    assign feat_known_o = word_i !== 16'h0000 && word_i !== 16'hFFFF;
    // flag is advisory only, nothing here acts on it
endmodule : idpw_host_model
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: directed scenarios for the identify word block
// Assumes: default parameters
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import idpw_pkg::*;
    logic clk_i = 0, srst_i = 1, ce_i = 0, en = 0, sec = 0, wc = 0, la = 0, apm = 0, hit, ext, fk;
    logic [1:0] md = 0;
    logic [7:0] rq = 0, idx, mc = 0;
    logic [15:0] cyl = 0, hd = 0, spt = 0, w;
    logic [31:0] lba = 0;
    int err_count = 0, num_checks = 0;
    always #25 clk_i = ~clk_i;
    idpw_words i_idpw_words (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .word_idx_i(idx), .cur_cyl_i(cyl),
        .cur_heads_i(hd), .cur_spt_i(spt), .lba_total_i(lba), .mult_count_i(mc), .mdma_sel_en_i(en),
        .mdma_sel_mode_i(md), .security_sup_i(sec), .wcache_sup_i(wc), .lookahead_sup_i(la), .apm_sup_i(apm),
        .word_o(w), .word_hit_o(hit), .ext_valid_o(ext));
    idpw_host_model i_idpw_host_model (.req_idx_i(rq), .word_i(w), .word_idx_o(idx), .feat_known_o(fk));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    task automatic rd(input logic [7:0] i, input logic [15:0] e);
        rq = i;
        @(posedge clk_i);
        #1;
        chk($sformatf("word %0d", i), e, w);
        chk("hit", (i >= 8'h36 && i <= 8'h54), hit);
    endtask : rd
    task automatic t_geom();
        logic [31:0] c;
        cyl = 16'h1234; hd = 16'h0010; spt = 16'h003F; lba = 32'h0123ABCD;
        c = 32'h1234 * 32'h10 * 32'h3F;
        rd(8'h36, 16'h1234); rd(8'h37, 16'h0010); rd(8'h38, 16'h003F);
        rd(8'h39, c[15:0]); rd(8'h3A, c[31:16]);
        rd(8'h3C, 16'hABCD); rd(8'h3D, 16'h0123);
        $display("geometry done");
    endtask : t_geom
    task automatic t_mult();
        mc = 8'h00; rd(8'h3B, 16'h0100);
        mc = 8'h08; rd(8'h3B, 16'h0101);
        mc = 8'h01; rd(8'h3B, 16'h0101);
        $display("multiple done");
    endtask : t_mult
    task automatic t_mdma();
        for (int i = 0; i < 8; i++) begin
            en = i[2]; md = i[1:0];
            rd(8'h3F, {5'h00, (en && md != 2'd3) ? 3'b001 << md : 3'b000, 8'h07});
        end
        $display("dma done");
    endtask : t_mdma
    task automatic t_cyc();
        rd(8'h40, 16'h0003);
        rd(8'h41, 16'h0078); rd(8'h42, 16'h0078);
        rd(8'h43, 16'h0078); rd(8'h44, 16'h0078);
        chk("ext", 1'b1, ext);
        $display("cycle times done");
    endtask : t_cyc
    task automatic t_feat();
        for (int i = 0; i < 16; i++) begin
            {sec, wc, la, apm} = i[3:0];
            rd(8'h52, 16'h7008 | {9'h0, la, wc, 3'h0, sec, 1'b0});
            rd(8'h53, 16'h4000 | {12'h0, apm, 3'h0});
            rd(8'h54, 16'h4000);
            chk("feature known", 1'b1, fk);
        end
        $display("features done");
    endtask : t_feat
    task automatic t_edge();
        rd(8'h35, 16'h0000); rd(8'h55, 16'h0000); rd(8'hFF, 16'h0000);
        rd(8'h3E, 16'h0000);
        chk("feature unknown", 1'b0, fk);
        rd(8'h36, 16'h1234);
        ce_i = 0; rq = 8'h54;
        repeat (3) @(posedge clk_i);
        #1;
        chk("frozen", 16'h1234, w);
        ce_i = 1;
        @(posedge clk_i);
        #1;
        chk("resumed", 16'h4000, w);
        $display("edges done");
    endtask : t_edge
    task automatic t_reset();
        srst_i = 1;
        @(posedge clk_i);
        #1;
        chk("mid reset word", 16'h0000, w);
        chk("mid reset hit", 1'b0, hit);
        chk("mid reset ext", 1'b0, ext);
        srst_i = 0;
        rd(8'h36, 16'h1234);
        chk("ext back", 1'b1, ext);
        $display("reset done");
    endtask : t_reset
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20) @(posedge clk_i);
        #1;
        chk("reset word", 16'h0000, w); chk("reset ext", 1'b0, ext);
        srst_i = 0; ce_i = 1;
        t_geom(); t_mult(); t_mdma(); t_cyc(); t_feat(); t_edge(); t_reset();
        finish_test();
    end
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
endmodule : tb_top
bind idpw_words idpw_monitor #(.EXT_SUP(EXT_SUP)) i_idpw_monitor (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .word_idx_i(word_idx_i), .cur_cyl_i(cur_cyl_i), .lba_total_i(lba_total_i), .mult_count_i(mult_count_i),
    .mdma_sel_en_i(mdma_sel_en_i), .mdma_sel_mode_i(mdma_sel_mode_i), .apm_sup_i(apm_sup_i), .word_o(word_o),
    .word_hit_o(word_hit_o), .ext_valid_o(ext_valid_o));
`default_nettype wire
